// ---- include/rss_pkg.sv ----
package rss_pkg;

  // Clock and timing counts; a least time rounds up to whole cycles.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POR_PULSE_NS = 150;
  localparam int POR_PULSE_CYC = (POR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] HOLD_CYC = 8'(POR_PULSE_CYC);
  localparam logic [3:0] BUZZ_WINDOW_CYC = 4'h8;

  // Register byte offsets.
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_TRIP = 32'h0000_0004;
  localparam logic [31:0] REG_BUZZ = 32'h0000_0008;
  localparam logic [31:0] REG_WDT_TIMEOUT = 32'h0000_000C;
  localparam logic [31:0] REG_WDT_KICK = 32'h0000_0010;
  localparam logic [31:0] REG_STATUS = 32'h0000_0014;
  localparam logic [31:0] REG_STATE = 32'h0000_0018;

  // Control register fields.
  localparam int CTRL_SW_RESET = 0;
  localparam int CTRL_SW_BLOCK = 1;
  localparam int CTRL_ANA_REG_EN = 2;
  localparam int CTRL_GPIO_RESET_EN = 3;
  localparam int CTRL_ALOW_RST_MODE = 4;
  localparam int CTRL_DLOW_RST_MODE = 5;
  localparam int CTRL_WDT_EN = 6;
  localparam int CTRL_ALOW_EN = 7;
  localparam int CTRL_DLOW_EN = 8;
  localparam int CTRL_AHIGH_EN = 9;
  localparam int CTRL_W = 10;

  // Status register fields, all sticky and write-one-to-clear.
  localparam int STAT_POWER_ON = 0;
  localparam int STAT_PRECISE = 1;
  localparam int STAT_EXTERNAL = 2;
  localparam int STAT_WATCHDOG = 3;
  localparam int STAT_SOFTWARE = 4;
  localparam int STAT_ALOW = 5;
  localparam int STAT_DLOW = 6;
  localparam int STAT_AHIGH = 7;

  // Reset values.
  localparam logic [9:0] CTRL_RST = 10'h004;
  localparam logic [7:0] TRIP_RST = 8'h00;
  localparam logic [15:0] BUZZ_RST = 16'h0100;
  localparam logic [31:0] WDT_TIMEOUT_RST = 32'h0001_0000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RSS_POR = 3'b001,
    RSS_HOLD = 3'b010,
    RSS_RUN = 3'b100
  } rss_state_t;

endpackage

// ---- hw/rss_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Supply or rail out of range resets device.
// - Supply monitors can raise interrupts before reset.
// - Low reset pin holds device in reset.
// - Unkicked watchdog past timeout resets device.
// - Software reset bit resets like power-on.
// - Block bit stops software reset taking effect.
// - Device reset returns configuration to reset values.
// - Status register records causes, cleared at power-on.
// - Power-on pulse lasts 150 ns, stretched while ramping.
// - After boot, initial monitor off, precise monitor on.
// - Precise monitor trip resets like power-on.
// - Digital precise monitor cannot be disabled.
// - Precise monitor off in sleep, except buzz windows.
// - Analog high interrupt at fixed 5.75 V.
// - Low trip levels 1.70 to 5.45 V, 250 mV.
// - Each low monitor may reset instead of interrupt.
// - Interrupt monitors off until boot, buzzed in sleep.
// - Wake first, then present a buzz-window interrupt.
// - Reset pin active low, pulled up, always live.
// - Power-on disables watchdog; enable sticks until power-on.
module rss_top
  import rss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_ramp_low,
  input wire logic analog_core_rail_low,
  input wire logic digital_core_rail_low,
  input wire logic analog_supply_low,
  input wire logic digital_supply_low,
  input wire logic analog_supply_high,
  input wire logic external_reset_pin_n,
  input wire logic gpio_reset_pin_n,
  input wire logic sleep_mode,
  input wire logic hibernate_mode,
  output logic device_reset_n,
  output logic initial_supply_reset_en,
  output logic precise_supply_reset_en,
  output logic supply_irq_monitor_en,
  output logic analog_regulator_en,
  output logic [3:0] analog_low_trip_code,
  output logic [3:0] digital_low_trip_code,
  output logic external_reset_pullup_en,
  output logic analog_low_supply_irq,
  output logic digital_low_supply_irq,
  output logic analog_high_supply_irq,
  output logic wakeup_request
);

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  rss_state_t state_r, state_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic boot_done_r, boot_done_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [7:0] trip_r, trip_nxt;
  logic [15:0] buzz_period_r, buzz_period_nxt, buzz_cnt_r, buzz_cnt_nxt;
  logic [3:0] buzz_win_r, buzz_win_nxt;
  logic [31:0] wdt_timeout_r, wdt_timeout_nxt, wdt_cnt_r, wdt_cnt_nxt;
  logic wdt_en_r, wdt_en_nxt;
  logic [7:0] status_r, status_nxt, w1c;
  logic rst_n_r, rst_n_nxt, initial_supply_reset_en_r, precise_supply_reset_en_r, mon_en_r, areg_r, pullup_r;
  logic alow_irq_r, dlow_irq_r, ahigh_irq_r, wake_r;
  logic alow_irq_nxt, dlow_irq_nxt, ahigh_irq_nxt, wake_nxt;
  logic [31:0] wmerged;
  logic wr_fire, dev_rst, buzz_on, precise_supply_reset_act, mon_act, external_reset_pin_req, precise_supply_reset_trip;
  logic alow_hit, dlow_hit, ahigh_hit, low_rst, software_reset_request_hit, wdt_fire, kick, any_req;

  // Monitor activity and the reset requests of every source.
  always_comb begin
    dev_rst = (state_r != RSS_RUN);
    wr_fire = aw_have_r && w_have_r && !bvalid_r;
    wmerged = merge(32'h0000_0000, wdata_r, wstrb_r);
    buzz_on = (buzz_win_r != 4'h0);
    // The pin is never gated by sleep or hibernate.
    external_reset_pin_req = !external_reset_pin_n || (ctrl_r[CTRL_GPIO_RESET_EN] && !gpio_reset_pin_n);
    precise_supply_reset_act = boot_done_r && !hibernate_mode && (!sleep_mode || buzz_on);
    precise_supply_reset_trip = precise_supply_reset_act && (digital_core_rail_low ||
                (analog_core_rail_low && ctrl_r[CTRL_ANA_REG_EN]));
    mon_act = boot_done_r && !hibernate_mode && (!sleep_mode || buzz_on);
    alow_hit = mon_act && ctrl_r[CTRL_ALOW_EN] && analog_supply_low;
    dlow_hit = mon_act && ctrl_r[CTRL_DLOW_EN] && digital_supply_low;
    ahigh_hit = mon_act && ctrl_r[CTRL_AHIGH_EN] && analog_supply_high;
    low_rst = (alow_hit && ctrl_r[CTRL_ALOW_RST_MODE]) ||
              (dlow_hit && ctrl_r[CTRL_DLOW_RST_MODE]);
    software_reset_request_hit = wr_fire && (awaddr_r == REG_CTRL) && wmerged[CTRL_SW_RESET] &&
               !ctrl_r[CTRL_SW_BLOCK] && !dev_rst;
    wdt_fire = wdt_en_r && !dev_rst && (wdt_cnt_r >= wdt_timeout_r);
    kick = wr_fire && (awaddr_r == REG_WDT_KICK);
    any_req = external_reset_pin_req || precise_supply_reset_trip || low_rst || software_reset_request_hit || wdt_fire;
  end

  // Reset sequencer: power-on pulse, then hold for every later request.
  // Level sources keep the hold alive; the release waits for all of them.
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    boot_done_nxt = boot_done_r;
    case (state_r)
      RSS_POR: begin
        if (hold_r != 8'h00) begin
          hold_nxt = hold_r - 8'h01;
        end else if (!supply_ramp_low && !external_reset_pin_req) begin
          state_nxt = RSS_RUN;
          boot_done_nxt = 1'b1;
        end
      end
      RSS_HOLD: begin
        if (hold_r != 8'h00) begin
          hold_nxt = hold_r - 8'h01;
        end else if (!external_reset_pin_req && !precise_supply_reset_trip && !low_rst) begin
          state_nxt = RSS_RUN;
        end
      end
      RSS_RUN: begin
        if (any_req) begin
          state_nxt = RSS_HOLD;
          hold_nxt = HOLD_CYC - 8'h01;
        end
      end
      default: begin
        state_nxt = RSS_POR;
        hold_nxt = HOLD_CYC - 8'h01;
      end
    endcase
    rst_n_nxt = (state_nxt == RSS_RUN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= RSS_POR;
      hold_r <= HOLD_CYC - 8'h01;
      boot_done_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      boot_done_r <= boot_done_nxt;
      rst_n_r <= rst_n_nxt;
    end
  end

  // AXI4-Lite slave. Address and data are taken in either order and the
  // response follows one cycle after both are held; reads answer next cycle.
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
      wready_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r[31:5] == 27'h0 && awaddr_r[1:0] == 2'h0 &&
                   awaddr_r <= REG_STATE) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_nxt = {22'h0, ctrl_r[9:7], wdt_en_r, ctrl_r[5:1], 1'b0};
        REG_TRIP: rdata_nxt = {24'h0, trip_r};
        REG_BUZZ: rdata_nxt = {16'h0, buzz_period_r};
        REG_WDT_TIMEOUT: rdata_nxt = wdt_timeout_r;
        REG_WDT_KICK: rdata_nxt = wdt_cnt_r;
        REG_STATUS: rdata_nxt = {24'h0, status_r};
        REG_STATE: rdata_nxt = {24'h0, boot_done_r, precise_supply_reset_act, mon_act, buzz_on, wdt_en_r,
                                state_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Configuration, watchdog, buzz timer and status. A device reset puts the
  // configuration back to reset values, but the status and the watchdog
  // enable survive it so that firmware can see why it restarted.
  always_comb begin
    ctrl_nxt = ctrl_r;
    trip_nxt = trip_r;
    buzz_period_nxt = buzz_period_r;
    wdt_timeout_nxt = wdt_timeout_r;
    wdt_en_nxt = wdt_en_r;
    w1c = 8'h00;
    if (wr_fire && !dev_rst) begin
      case (awaddr_r)
        REG_CTRL: begin
          ctrl_nxt = CTRL_W'(merge({22'h0, ctrl_r}, wdata_r, wstrb_r));
          ctrl_nxt[CTRL_SW_RESET] = 1'b0;
          wdt_en_nxt = wdt_en_r || wmerged[CTRL_WDT_EN];
        end
        REG_TRIP: trip_nxt = 8'(merge({24'h0, trip_r}, wdata_r, wstrb_r));
        REG_BUZZ: buzz_period_nxt = 16'(merge({16'h0, buzz_period_r}, wdata_r, wstrb_r));
        REG_WDT_TIMEOUT: wdt_timeout_nxt = merge(wdt_timeout_r, wdata_r, wstrb_r);
        REG_STATUS: w1c = wmerged[7:0];
        default: w1c = 8'h00;
      endcase
    end
    // Configuration that arms a level source survives while that source still
    // holds the reset, or a pin role or reset mode would drop after one cycle.
    if (dev_rst && !external_reset_pin_req && !precise_supply_reset_trip && !low_rst) begin
      ctrl_nxt = CTRL_RST;
      trip_nxt = TRIP_RST;
      buzz_period_nxt = BUZZ_RST;
      wdt_timeout_nxt = WDT_TIMEOUT_RST;
    end
    // The counter restarts on a kick, on reset, and while disabled.
    if (dev_rst || !wdt_en_r || kick) begin
      wdt_cnt_nxt = 32'h0000_0000;
    end else begin
      wdt_cnt_nxt = wdt_cnt_r + 32'h0000_0001;
    end
    // Buzz windows only open while asleep; firmware picks the interval.
    buzz_cnt_nxt = 16'h0000;
    buzz_win_nxt = 4'h0;
    if (sleep_mode && !hibernate_mode && !dev_rst) begin
      buzz_win_nxt = buzz_on ? buzz_win_r - 4'h1 : 4'h0;
      if (buzz_cnt_r >= buzz_period_r) begin
        buzz_win_nxt = BUZZ_WINDOW_CYC;
      end else begin
        buzz_cnt_nxt = buzz_cnt_r + 16'h0001;
      end
    end
    // A hardware set in the same cycle as a clear wins.
    status_nxt = status_r & ~w1c;
    status_nxt[STAT_POWER_ON] = status_nxt[STAT_POWER_ON] || boot_done_nxt && !boot_done_r;
    status_nxt[STAT_PRECISE] = status_nxt[STAT_PRECISE] || precise_supply_reset_trip;
    status_nxt[STAT_EXTERNAL] = status_nxt[STAT_EXTERNAL] || (external_reset_pin_req && boot_done_r);
    status_nxt[STAT_WATCHDOG] = status_nxt[STAT_WATCHDOG] || wdt_fire;
    status_nxt[STAT_SOFTWARE] = status_nxt[STAT_SOFTWARE] || software_reset_request_hit;
    status_nxt[STAT_ALOW] = status_nxt[STAT_ALOW] || alow_hit;
    status_nxt[STAT_DLOW] = status_nxt[STAT_DLOW] || dlow_hit;
    status_nxt[STAT_AHIGH] = status_nxt[STAT_AHIGH] || ahigh_hit;
    // Interrupts wait until the wake sequence has left sleep.
    alow_irq_nxt = status_r[STAT_ALOW] && !ctrl_r[CTRL_ALOW_RST_MODE] && !sleep_mode;
    dlow_irq_nxt = status_r[STAT_DLOW] && !ctrl_r[CTRL_DLOW_RST_MODE] && !sleep_mode;
    ahigh_irq_nxt = status_r[STAT_AHIGH] && !sleep_mode;
    wake_nxt = sleep_mode && (alow_hit || dlow_hit || ahigh_hit || wake_r);
  end

  // Power-on is the only reset that clears status and the watchdog enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      trip_r <= TRIP_RST;
      buzz_period_r <= BUZZ_RST;
      wdt_timeout_r <= WDT_TIMEOUT_RST;
      wdt_en_r <= 1'b0;
      wdt_cnt_r <= 32'h0000_0000;
      buzz_cnt_r <= 16'h0000;
      buzz_win_r <= 4'h0;
      status_r <= 8'h00;
      alow_irq_r <= 1'b0;
      dlow_irq_r <= 1'b0;
      ahigh_irq_r <= 1'b0;
      wake_r <= 1'b0;
      initial_supply_reset_en_r <= 1'b1;
      precise_supply_reset_en_r <= 1'b0;
      mon_en_r <= 1'b0;
      areg_r <= 1'b1;
      pullup_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      trip_r <= trip_nxt;
      buzz_period_r <= buzz_period_nxt;
      wdt_timeout_r <= wdt_timeout_nxt;
      wdt_en_r <= wdt_en_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      buzz_cnt_r <= buzz_cnt_nxt;
      buzz_win_r <= buzz_win_nxt;
      status_r <= status_nxt;
      alow_irq_r <= alow_irq_nxt;
      dlow_irq_r <= dlow_irq_nxt;
      ahigh_irq_r <= ahigh_irq_nxt;
      wake_r <= wake_nxt;
      initial_supply_reset_en_r <= !boot_done_nxt;
      precise_supply_reset_en_r <= precise_supply_reset_act;
      mon_en_r <= mon_act;
      areg_r <= ctrl_nxt[CTRL_ANA_REG_EN];
      pullup_r <= 1'b1;
    end
  end

  // Output flops onto ports.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign device_reset_n = rst_n_r;
  assign initial_supply_reset_en = initial_supply_reset_en_r;
  assign precise_supply_reset_en = precise_supply_reset_en_r;
  assign supply_irq_monitor_en = mon_en_r;
  assign analog_regulator_en = areg_r;
  assign analog_low_trip_code = trip_r[3:0];
  assign digital_low_trip_code = trip_r[7:4];
  assign external_reset_pullup_en = pullup_r;
  assign analog_low_supply_irq = alow_irq_r;
  assign digital_low_supply_irq = dlow_irq_r;
  assign analog_high_supply_irq = ahigh_irq_r;
  assign wakeup_request = wake_r;

  // Checks on the sequencer and monitors.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] age_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_r <= 8'h00;
    end else if (age_r != 8'hFF) begin
      age_r <= age_r + 8'h01;
    end
  end

  a_por_pulse_width: assert property (device_reset_n |-> age_r >= HOLD_CYC)
    else $error("power-on reset released too early");
  a_ramp_stretch: assert property ((state_r == RSS_POR && supply_ramp_low) |=> !device_reset_n)
    else $error("reset released while a supply still ramps");
  a_pin_holds_reset: assert property (!external_reset_pin_n |=> !device_reset_n)
    else $error("reset pin low but device not in reset");
  a_soft_reset: assert property (software_reset_request_hit |=> !device_reset_n [*8])
    else $error("software reset did not hold the device reset");
  a_soft_blocked: assert property ((wr_fire && awaddr_r == REG_CTRL && wmerged[CTRL_SW_RESET]
      && ctrl_r[CTRL_SW_BLOCK]) |-> !software_reset_request_hit)
    else $error("blocked software reset still requested");
  a_wdt_timeout: assert property ((state_r == RSS_RUN && wdt_en_r && wdt_cnt_r >= wdt_timeout_r)
      |=> !device_reset_n ##1 (status_r[STAT_WATCHDOG]))
    else $error("watchdog expiry did not reset");
  a_wdt_sticky: assert property (wdt_en_r |=> wdt_en_r)
    else $error("watchdog enable dropped without power-on");
  a_precise_trip: assert property ((state_r == RSS_RUN && precise_supply_reset_act && digital_core_rail_low)
      |=> !device_reset_n)
    else $error("precise monitor trip did not reset");
  a_sleep_monitors: assert property ((sleep_mode && buzz_win_r == 4'h0) |-> !precise_supply_reset_act && !mon_act)
    else $error("monitor active in sleep outside a buzz window");
  a_irq_after_wake: assert property ((sleep_mode && $past(sleep_mode)) |-> !analog_low_supply_irq
      && !digital_low_supply_irq && !analog_high_supply_irq)
    else $error("interrupt presented before wakeup");
  a_status_set: assert property (alow_hit |=> status_r[STAT_ALOW])
    else $error("analog low event not recorded");

  c_boot_done: cover property ($rose(device_reset_n));
  c_pin_reset: cover property (device_reset_n ##1 !external_reset_pin_n ##1 !device_reset_n);
  c_wdt_fire: cover property (wdt_fire ##1 !device_reset_n);
  c_buzz_irq: cover property (sleep_mode && buzz_on && alow_hit ##[1:50] analog_low_supply_irq);

endmodule
`default_nettype wire

// ---- sim/rss_pin_driver.sv ----
`timescale 1ns/10ps
`default_nettype none
// Board-side pusher on the reset pin; a released pin is driven back high by this model.
module rss_pin_driver #(
  parameter int GAP_CYC = 2000
) (
  input wire logic aclk,
  input wire logic push_req,
  output var logic pin_n
);
  int gap_cnt = GAP_CYC;
  initial pin_n = 1'h1;
  // A new push is held off until the pin has stayed high for the spacing time.
  always @(posedge aclk) begin
    if (push_req && (!pin_n || gap_cnt >= GAP_CYC)) begin
      pin_n <= 1'h0;
      gap_cnt <= 0;
    end else begin
      pin_n <= 1'h1;
      if (gap_cnt < GAP_CYC) gap_cnt <= gap_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/reset_source_supervisor_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module reset_source_supervisor_test;
  import rss_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd, t;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, push = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic supply_ramp_low = 1'h0, analog_core_rail_low = 1'h0, digital_core_rail_low = 1'h0;
  logic analog_supply_low = 1'h0, digital_supply_low = 1'h0, analog_supply_high = 1'h0;
  logic gpio_reset_pin_n = 1'h1, sleep_mode = 1'h0, hibernate_mode = 1'h0;
  logic external_reset_pin_n, device_reset_n, initial_supply_reset_en, precise_supply_reset_en;
  logic supply_irq_monitor_en, analog_regulator_en, external_reset_pullup_en, wakeup_request;
  logic [3:0] analog_low_trip_code, digital_low_trip_code;
  logic analog_low_supply_irq, digital_low_supply_irq, analog_high_supply_irq;
  int mismatches = 0, check_count = 0, low_run = 0, last_low = 0, n;
  localparam int SB [5] = '{STAT_EXTERNAL, STAT_PRECISE, STAT_SOFTWARE, STAT_EXTERNAL, STAT_DLOW};

  rss_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .supply_ramp_low, .analog_core_rail_low, .digital_core_rail_low,
    .analog_supply_low, .digital_supply_low, .analog_supply_high, .external_reset_pin_n,
    .gpio_reset_pin_n, .sleep_mode, .hibernate_mode, .device_reset_n, .initial_supply_reset_en,
    .precise_supply_reset_en, .supply_irq_monitor_en, .analog_regulator_en,
    .analog_low_trip_code, .digital_low_trip_code, .external_reset_pullup_en,
    .analog_low_supply_irq, .digital_low_supply_irq, .analog_high_supply_irq, .wakeup_request);
  rss_pin_driver i_pin (.aclk(aclk), .push_req(push), .pin_n(external_reset_pin_n));

  // The clock runs at 200 MHz.
  always #2.5 aclk = ~aclk;

  // Measures how long each device reset lasted, so its minimum width can be judged.
  always @(posedge aclk) begin
    if (!device_reset_n) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Expected pair of trip codes for a written trip word, analog code first.
  function automatic logic [31:0] exp_codes(input logic [31:0] w);
    return 32'({w[3:0], w[7:4]});
  endfunction

  // One clock edge of a bounded wait; a wait that runs too long ends the run.
  task automatic tick(inout int c);
    @(posedge aclk);
    c++;
    if (c > 3000) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    int c;
    logic aw, w;
    c = 0;
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      tick(c);
      if (!aw && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (!w && s_axi_wready) s_axi_wvalid <= 1'h0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end
    s_axi_bready <= 1'h1;
    do tick(c); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(e));
  endtask

  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int c;
    c = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do tick(c); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do tick(c); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Waits for the device reset to end; writes during it would be dropped.
  task automatic wait_up;
    int c;
    c = 0;
    while (device_reset_n !== 1'h1) tick(c);
    @(posedge aclk);
  endtask

  // Main sequence: boot, registers, monitors, reset sources, watchdog, second power-on.
  initial begin
    t = $urandom(32'h7400D8BE);
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    n = 0;
    while (device_reset_n !== 1'h1) tick(n);
    chk(32'(n >= 31), 1);
    rd_reg(REG_CTRL, rd, rr);
    chk(rd, 32'(CTRL_RST));
    rd_reg(REG_BUZZ, rd, rr);
    chk(rd, 32'(BUZZ_RST));
    rd_reg(REG_STATUS, rd, rr);
    chk(32'(rd[STAT_POWER_ON]), 1);
    chk(32'({initial_supply_reset_en, precise_supply_reset_en}), 1);
    chk(32'({supply_irq_monitor_en, external_reset_pullup_en}), 3);
    rd_reg(32'h0000_0040, rd, rr);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(32'h0000_0042, 32'h0, RESP_SLVERR);
    repeat (4) begin
      t = $urandom;
      wr(REG_TRIP, t, RESP_OKAY);
      @(posedge aclk);
      chk(32'({analog_low_trip_code, digital_low_trip_code}), exp_codes(t));
    end
    wr(REG_BUZZ, 32'h4, RESP_OKAY);
    wr(REG_CTRL, 32'h384, RESP_OKAY);
    {analog_supply_low, digital_supply_low, analog_supply_high} <= 3'h7;
    repeat (4) @(posedge aclk);
    chk(32'({analog_low_supply_irq, digital_low_supply_irq, analog_high_supply_irq}), 7);
    chk(32'(device_reset_n), 1);
    sleep_mode <= 1'h1;
    repeat (3) @(posedge aclk);
    chk(32'(analog_high_supply_irq), 0);
    n = 0;
    while (wakeup_request !== 1'h1) tick(n);
    sleep_mode <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(32'({analog_high_supply_irq, wakeup_request}), 2);
    {analog_supply_low, digital_supply_low, analog_supply_high} <= 3'h0;
    @(posedge aclk);
    wr(REG_STATUS, 32'hFF, RESP_OKAY);
    rd_reg(REG_STATUS, rd, rr);
    chk(rd & 32'hFF, 0);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    analog_core_rail_low <= 1'h1;
    repeat (40) @(posedge aclk);
    chk(32'({analog_regulator_en, device_reset_n}), 1);
    analog_core_rail_low <= 1'h0;
    wr(REG_CTRL, 32'h6, RESP_OKAY);
    wr(REG_CTRL, 32'h7, RESP_OKAY);
    repeat (40) @(posedge aclk);
    chk(32'(device_reset_n), 1);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: push <= 1'h1;
        1: digital_core_rail_low <= 1'h1;
        2: wr(REG_CTRL, 32'h1, RESP_OKAY);
        3: begin
          wr(REG_CTRL, 32'hC, RESP_OKAY);
          gpio_reset_pin_n <= 1'h0;
        end
        default: begin
          wr(REG_CTRL, 32'h124, RESP_OKAY);
          digital_supply_low <= 1'h1;
        end
      endcase
      // A software reset is a pulse, so it is looked at while its fixed hold runs.
      repeat ((k == 2) ? 20 : 40) @(posedge aclk);
      chk(32'(device_reset_n), 0);
      {push, digital_core_rail_low, digital_supply_low, gpio_reset_pin_n} <= 4'h1;
      wait_up();
      chk(32'(last_low >= ((k == 2) ? 30 : 38)), 1);
      rd_reg(REG_STATUS, rd, rr);
      chk(32'(rd[SB[k]]), 1);
      rd_reg(REG_CTRL, rd, rr);
      chk(rd, 32'(CTRL_RST));
      wr(REG_STATUS, 32'hFF, RESP_OKAY);
    end
    wr(REG_WDT_TIMEOUT, 32'h40, RESP_OKAY);
    wr(REG_CTRL, 32'h44, RESP_OKAY);
    repeat (5) begin
      repeat (20) @(posedge aclk);
      wr(REG_WDT_KICK, 32'h0, RESP_OKAY);
    end
    chk(32'(device_reset_n), 1);
    n = 0;
    while (device_reset_n !== 1'h0) tick(n);
    chk(32'(n >= 60 && n <= 70), 1);
    wait_up();
    wr(REG_CTRL, 32'h4, RESP_OKAY);
    rd_reg(REG_STATUS, rd, rr);
    chk(32'(rd[STAT_WATCHDOG]), 1);
    rd_reg(REG_STATE, rd, rr);
    chk(32'(rd[3]), 1);
    // Second power-on with a slow supply: the reset must stretch past its pulse.
    {aresetn, supply_ramp_low} <= 2'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (50) @(posedge aclk);
    chk(32'(device_reset_n), 0);
    supply_ramp_low <= 1'h0;
    wait_up();
    rd_reg(REG_STATE, rd, rr);
    chk(32'(rd[3]), 0);
    rd_reg(REG_STATUS, rd, rr);
    chk(rd & 32'hFF, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
